//--- osu_pkg.sv
package osu_pkg;
   // Core clock and the on-chip RC oscillator that sets the bit rate
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OSC_HZ = 87_800;
   // Oscillator periods per receive phase for each speed setting
   localparam int unsigned OSC_PER_PHASE_SLOW = 2;
   localparam int unsigned OSC_PER_PHASE_FAST = 1;
   // Core clock cycles per phase tick, rounded down
   localparam int unsigned DIV_SLOW_CYC = CLK_HZ * OSC_PER_PHASE_SLOW / OSC_HZ;
   localparam int unsigned DIV_FAST_CYC = CLK_HZ * OSC_PER_PHASE_FAST / OSC_HZ;
   localparam int unsigned DIV_W = 16;

   // Character framing
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned BIT_IDX_W = 3;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT = 3'h7;
   localparam logic START_LEVEL = 1'b0;
   localparam logic STOP_LEVEL = 1'b1;

   // Sixteen phases per bit; vote over the three centre phases
   localparam int unsigned PHASE_W = 4;
   localparam logic [PHASE_W-1:0] PHASE_FIRST_VOTE = 4'h6;
   localparam logic [PHASE_W-1:0] PHASE_LAST_VOTE = 4'h8;
   localparam logic [PHASE_W-1:0] PHASE_LAST = 4'hf;

   // Transmit buffer
   localparam int unsigned BUF_DEPTH = 2;
   localparam int unsigned BUF_PTR_W = 1;
   localparam int unsigned BUF_CNT_W = 2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_STOP = 2'b11
   } osu_state_t;
endpackage

//--- osu_uart.sv
`timescale 1ns/1ps
module osu_uart #(
   parameter int unsigned DATA_W = osu_pkg::DATA_BITS,
   parameter int unsigned DIV_SLOW = osu_pkg::DIV_SLOW_CYC,
   parameter int unsigned DIV_FAST = osu_pkg::DIV_FAST_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic fast_rate_select,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic tx_line,
   output logic tx_irq,
   input wire logic rx_line,
   output logic [DATA_W-1:0] rx_data,
   output logic rx_full,
   input wire logic rx_read,
   output logic rx_irq
);
   import osu_pkg::*;

   localparam logic [DIV_W-1:0] LIM_SLOW = DIV_W'(DIV_SLOW - 1);
   localparam logic [DIV_W-1:0] LIM_FAST = DIV_W'(DIV_FAST - 1);

   logic [DIV_W-1:0] div_cnt;
   logic [DIV_W-1:0] div_lim;
   logic tick;

   logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
   logic [BUF_PTR_W-1:0] buf_wr;
   logic [BUF_PTR_W-1:0] buf_rd;
   logic [BUF_CNT_W-1:0] buf_cnt;
   logic [BUF_CNT_W-1:0] next_buf_cnt;
   logic buf_push;
   logic buf_pop;

   osu_state_t tx_state;
   logic [PHASE_W-1:0] tx_phase;
   logic [BIT_IDX_W-1:0] tx_bit;
   logic [DATA_W-1:0] tx_shift;

   osu_state_t rx_state;
   logic [PHASE_W-1:0] rx_phase;
   logic [BIT_IDX_W-1:0] rx_bit;
   logic [DATA_W-1:0] rx_shift;
   logic rx_prev;
   logic rx_filt;
   logic rx_last;
   logic [1:0] rx_smp;
   logic rx_vote;
   logic rx_vote_now;
   logic rx_capture;

   // Majority of three samples
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // Phase tick at sixteen times the bit rate; one divider serves both paths
   assign div_lim = fast_rate_select ? LIM_FAST : LIM_SLOW;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else if (div_cnt >= div_lim) begin // Compare, so a speed change mid-count cannot overrun
         div_cnt <= '0;
         tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   // Two-entry transmit buffer; ready drops when full so the writer stalls
   assign buf_push = tx_valid & tx_ready;
   assign buf_pop = (tx_state == ST_IDLE) && (buf_cnt != '0);
   always_comb begin
      next_buf_cnt = buf_cnt;
      if (buf_push && !buf_pop) begin
         next_buf_cnt = buf_cnt + 1'b1;
      end else if (buf_pop && !buf_push) begin
         next_buf_cnt = buf_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_wr <= '0;
         buf_rd <= '0;
         buf_cnt <= '0;
         tx_ready <= 1'b1;
      end else begin
         if (buf_push) begin
            buf_wr <= buf_wr + 1'b1;
         end
         if (buf_pop) begin
            buf_rd <= buf_rd + 1'b1;
         end
         buf_cnt <= next_buf_cnt;
         tx_ready <= (next_buf_cnt != BUF_CNT_W'(BUF_DEPTH));
      end
   end

   // Storage needs no reset; entries are read only after being written
   always_ff @(posedge clk) begin
      if (buf_push) begin
         buf_mem[buf_wr] <= tx_data;
      end
   end

   // Transmitter: a buffered byte leaves at once, start bit on the next edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_state <= ST_IDLE;
         tx_phase <= '0;
         tx_bit <= '0;
         tx_shift <= '0;
         tx_line <= STOP_LEVEL;
         tx_irq <= 1'b0;
      end else begin
         tx_irq <= 1'b0;
         case (tx_state)
            ST_IDLE: begin
               if (buf_pop) begin
                  tx_shift <= buf_mem[buf_rd];
                  tx_line <= START_LEVEL;
                  tx_phase <= '0;
                  tx_bit <= '0;
                  tx_state <= ST_START;
               end
            end
            ST_START: begin
               if (tick) begin
                  tx_phase <= tx_phase + 1'b1;
                  if (tx_phase == PHASE_LAST) begin
                     tx_line <= tx_shift[0];
                     tx_state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (tick) begin
                  tx_phase <= tx_phase + 1'b1;
                  if (tx_phase == PHASE_LAST) begin
                     tx_bit <= tx_bit + 1'b1;
                     if (tx_bit == LAST_BIT) begin
                        tx_line <= STOP_LEVEL;
                        tx_irq <= 1'b1;
                        tx_state <= ST_STOP;
                     end else begin
                        tx_line <= tx_shift[1];
                        tx_shift <= {1'b0, tx_shift[DATA_W-1:1]};
                     end
                  end
               end
            end
            ST_STOP: begin
               if (tick) begin
                  tx_phase <= tx_phase + 1'b1;
                  if (tx_phase == PHASE_LAST) begin
                     tx_state <= ST_IDLE;
                  end
               end
            end
            default: begin
               tx_state <= ST_IDLE;
               tx_line <= STOP_LEVEL;
            end
         endcase
      end
   end

   // Debounce: the filtered level only follows two equal tick samples
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_prev <= STOP_LEVEL;
         rx_filt <= STOP_LEVEL;
         rx_last <= STOP_LEVEL;
      end else if (tick) begin
         rx_prev <= rx_line;
         rx_last <= rx_filt;
         if (rx_line == rx_prev) begin
            rx_filt <= rx_line;
         end
      end
   end

   // Vote is formed on the last centre phase from the two earlier samples and the current filtered level
   assign rx_vote = maj3(rx_smp[1], rx_smp[0], rx_filt);
   assign rx_vote_now = tick && (rx_phase == PHASE_LAST_VOTE);
   assign rx_capture = rx_vote_now && (rx_state == ST_STOP);

   // Receiver sequence; runs independently of the transmitter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_state <= ST_IDLE;
         rx_phase <= '0;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_smp <= '0;
      end else begin
         if (tick && rx_state != ST_IDLE) begin
            rx_phase <= rx_phase + 1'b1;
            if (rx_phase >= PHASE_FIRST_VOTE && rx_phase < PHASE_LAST_VOTE) begin
               rx_smp <= {rx_smp[0], rx_filt};
            end
         end
         case (rx_state)
            ST_IDLE: begin
               if (tick && rx_last && !rx_filt) begin
                  rx_phase <= '0;
                  rx_bit <= '0;
                  rx_state <= ST_START;
               end
            end
            ST_START: begin
               if (rx_vote_now && rx_vote) begin
                  rx_state <= ST_IDLE;
               end else if (tick && rx_phase == PHASE_LAST) begin
                  rx_state <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (rx_vote_now) begin
                  rx_shift <= {rx_vote, rx_shift[DATA_W-1:1]};
               end
               if (tick && rx_phase == PHASE_LAST) begin
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == LAST_BIT) begin
                     rx_state <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (rx_vote_now) begin
                  rx_state <= ST_IDLE; // Back to idle at mid stop bit to catch the next edge
               end
            end
            default: begin
               rx_state <= ST_IDLE;
            end
         endcase
      end
   end

   // Holding register; a new byte overwrites an unread one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_data <= '0;
         rx_full <= 1'b0;
         rx_irq <= 1'b0;
      end else begin
         rx_irq <= rx_capture;
         if (rx_capture) begin
            rx_data <= rx_shift;
            rx_full <= 1'b1; // Set wins over a read in the same cycle
         end else if (rx_read) begin
            rx_full <= 1'b0;
         end
      end
   end
endmodule

//--- osu_uart_end.sv
`timescale 1ns/1ps

//--- osu_uart_monitor.sv
`timescale 1ns/1ps
// Port-level checks of the serial framing and the event pulses
module osu_uart_monitor #(
   parameter int unsigned DATA_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_line,
   input wire logic tx_irq,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic rx_full,
   input wire logic rx_read,
   input wire logic rx_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Eight cycles is far below one bit even at the fastest tick
   sequence low_run;
      !tx_line [*8];
   endsequence
   sequence high_run;
      tx_line [*8];
   endsequence
   start_low_a: assert property ($fell(tx_line) |-> low_run) else $error("start bit too short");
   stop_high_a: assert property (tx_irq |-> high_run) else $error("stop not driven with irq");
   tx_pulse_a: assert property (tx_irq |=> !tx_irq [*8]) else $error("tx irq not a pulse");
   rx_full_a: assert property (rx_irq |-> rx_full) else $error("capture without full");
   rx_pulse_a: assert property (rx_irq |=> !rx_irq [*8]) else $error("rx irq not a pulse");
   rx_keep_a: assert property ($changed(rx_data) |-> rx_irq) else $error("held byte moved");
   rx_clear_a: assert property (rx_read && !rx_irq |=> !rx_full || rx_irq) else $error("read kept full");
   rx_hold_a: assert property ($fell(rx_full) |-> $past(rx_read)) else $error("full lost unread");
endmodule
bind osu_uart osu_uart_monitor #(.DATA_W(DATA_W)) mon_u (.clk(clk), .rst(rst), .tx_line(tx_line),
   .tx_irq(tx_irq), .rx_data(rx_data), .rx_full(rx_full), .rx_read(rx_read), .rx_irq(rx_irq));

//--- osu_host.sv
`timescale 1ns/1ps
// Host serial port: drives the receive line, decodes the transmit line
module osu_host (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   int bit_cyc = 64;
   logic [7:0] got [$];
   logic [7:0] sh;
   initial line_out = 1'b1;
   // One character, LSB first, changed on the falling clock
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out = f[i];
         repeat (bit_cyc) @(negedge clk);
      end
   endtask
   // Low pulse used as a spike or a false start
   task automatic pulse(input int n);
      line_out = 1'b0;
      repeat (n) @(negedge clk);
      line_out = 1'b1;
   endtask
   // Sample at bit centres on the falling clock, where the registered line has settled
   always begin
      @(negedge line_in);
      repeat (bit_cyc / 2) @(negedge clk);
      if (!line_in) begin
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(negedge clk);
            sh[i] = line_in;
         end
         repeat (bit_cyc) @(negedge clk);
         if (line_in) got.push_back(sh);
      end
   end
endmodule

//--- test_oversampled_serial_uart.sv
`timescale 1ns/1ps
module test_oversampled_serial_uart;
   import osu_pkg::*;
   // Small dividers keep each bit at 64 or 32 cycles
   localparam int unsigned DS = 4;
   localparam int unsigned DF = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fast_rate_select = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic rx_read = 1'b0;
   logic tx_ready, tx_line, tx_irq, rx_line, rx_full, rx_irq;
   logic [7:0] rx_data;
   int num_errors = 0;
   int n_tests = 0;
   int tx_irqs = 0;
   int rx_irqs = 0;
   int cyc = 0;
   bit saw_full;
   always #5 clk = ~clk;
   osu_uart #(.DIV_SLOW(DS), .DIV_FAST(DF)) dut_u (.clk(clk), .rst(rst), .fast_rate_select(fast_rate_select),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line), .tx_irq(tx_irq),
      .rx_line(rx_line), .rx_data(rx_data), .rx_full(rx_full), .rx_read(rx_read), .rx_irq(rx_irq));
   osu_host host_u (.clk(clk), .line_in(tx_line), .line_out(rx_line));
   // Pulses are counted on the falling clock, away from the edge that launches them
   always @(negedge clk) begin
      if (tx_irq === 1'b1) tx_irqs <= tx_irqs + 1;
      if (rx_irq === 1'b1) rx_irqs <= rx_irqs + 1;
   end
   // The cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   // Holds valid and data until an edge that saw ready; leaves valid high
   task automatic put(input logic [7:0] b);
      logic r;
      int n;
      n = 0;
      tx_data = b;
      tx_valid = 1'b1;
      do begin
         r = tx_ready;
         if (r !== 1'b1) saw_full = 1'b1;
         @(negedge clk);
         n++;
      end while (r !== 1'b1 && n < 3000);
   endtask
   task automatic t_reset();
      check(tx_line === 1'b1 && tx_ready === 1'b1 && tx_irq === 1'b0, "tx reset");
      check(rx_full === 1'b0 && rx_irq === 1'b0 && rx_data === 8'h00, "rx reset");
      $display("test reset done");
   endtask
   // Four writes back to back overfill the buffer; all bytes must still arrive
   task automatic t_tx();
      logic [7:0] v [4] = '{8'ha5, 8'h01, 8'hff, 8'h80};
      int n;
      n = 0;
      saw_full = 1'b0;
      tx_irqs = 0;
      foreach (v[i]) put(v[i]);
      tx_valid = 1'b0;
      while (host_u.got.size() < 4 && n < 8000) begin
         @(negedge clk);
         n++;
      end
      check(saw_full, "buffer never refused");
      foreach (v[i]) check(host_u.got[i] === v[i], "tx byte");
      check(tx_irqs == 4, "tx irq count");
      $display("test tx done");
   endtask
   // Second byte lands unread and replaces the first
   task automatic t_rx();
      rx_irqs = 0;
      host_u.send(8'h5a);
      check(rx_data === 8'h5a && rx_full === 1'b1, "rx first");
      host_u.send(8'hc3);
      repeat (DS * 16) @(negedge clk);
      check(rx_irqs == 2 && rx_data === 8'hc3, "rx overwrite");
      rx_read = 1'b1;
      @(negedge clk);
      rx_read = 1'b0;
      @(negedge clk);
      check(rx_full === 1'b0, "rx read");
      $display("test rx done");
   endtask
   // A spike and a short false start give nothing; a real byte still does
   task automatic t_spike();
      rx_irqs = 0;
      host_u.pulse(2);
      repeat (DS * 40) @(negedge clk);
      host_u.pulse(DS * 5);
      repeat (DS * 200) @(negedge clk);
      check(rx_irqs == 0 && rx_full === 1'b0, "glitch taken");
      host_u.send(8'h81);
      repeat (DS * 8) @(negedge clk);
      check(rx_irqs == 1 && rx_data === 8'h81, "rx after glitch");
      $display("test spike done");
   endtask
   // Both directions at once on the fast rate
   task automatic t_duplex();
      int n;
      n = 0;
      fast_rate_select = 1'b1;
      host_u.bit_cyc = DF * 16;
      host_u.got.delete();
      fork
         host_u.send(8'h96);
         begin
            put(8'h3c);
            tx_valid = 1'b0;
         end
      join
      while (host_u.got.size() < 1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check(host_u.got[0] === 8'h3c, "fast tx");
      check(rx_data === 8'h96, "fast rx");
      $display("test duplex done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_tx();
      t_rx();
      t_spike();
      t_duplex();
      conclude();
   end
endmodule
